// *** inc/rugi_regs.svh ***
`ifndef RUGI_REGS_SVH
`define RUGI_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RUGI_UART_OFS        8'h50
`define RUGI_REV_OFS         8'hb0
`define RUGI_GLOBAL_OFS      8'hb2
`define RUGI_INTEN1_OFS      8'hb3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RUGI_UART_RST        8'h02
`define RUGI_GLOBAL_RST      8'h00
`define RUGI_INTEN1_RST      8'h00
// Arbitrary neutral revision value
`define RUGI_REV_DEFAULT     8'h5a

// ----------------------------------------------------------------
// Passthrough control fields
// ----------------------------------------------------------------
`define RUGI_UART_RSV_HI     7
`define RUGI_UART_RSV_LO     6
`define RUGI_UART_SWAP       4
`define RUGI_UART_QUAL       3
`define RUGI_UART_DIR        2
`define RUGI_UART_SEL        1
`define RUGI_UART_EN         0

// ----------------------------------------------------------------
// Global configuration fields
// ----------------------------------------------------------------
`define RUGI_GLB_SOFT_RST    7
`define RUGI_GLB_PORT_DIS    6
`define RUGI_GLB_DRIVE       4
`define RUGI_GLB_POL         3

// ----------------------------------------------------------------
// Interrupt enable fields
// ----------------------------------------------------------------
`define RUGI_IE_RISE         7
`define RUGI_IE_FALL         6
`define RUGI_IE_WAKE         3
`define RUGI_IE_DISC         2
// Trigger kind kept in a spare bit of the same register
`define RUGI_IE_KIND         0

`endif

// *** inc/rugi_pkg.sv ***
package rugi_pkg;

    // Port disable sequencing
    typedef enum logic [1:0] {
        PORT_ON,
        PORT_WAIT,
        PORT_OFF
    } rugi_port_st_t;

    // Passthrough control fields
    typedef struct packed {
        logic [1:0] spare;
        logic       swap;
        logic       qual;
        logic       dir;
        logic       sel;
        logic       en;
    } rugi_uart_cfg_t;

endpackage : rugi_pkg

// *** inc/rugi_irq_if.sv ***
`timescale 1ns/1ns

interface rugi_irq_if;
    logic rise_en;
    logic fall_en;
    logic kind_level;
    logic wake_en;
    logic disc_en;
    logic input_one;
    logic wake_status;
    logic disc_status;
    logic edge_ack;
    logic irq_active;

    modport cfg (
        output rise_en, fall_en, kind_level, wake_en, disc_en,
        output input_one, wake_status, disc_status, edge_ack,
        input  irq_active
    );
    modport irq (
        input  rise_en, fall_en, kind_level, wake_en, disc_en,
        input  input_one, wake_status, disc_status, edge_ack,
        output irq_active
    );
endinterface : rugi_irq_if

// *** design/rugi_irq.sv ***
`timescale 1ns/1ns

module rugi_irq (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_clr,
    // Configuration and events
    rugi_irq_if.irq  irq_bus
);

    // ----------------------------------------------------------------
    // Edge detection on synchronised input one
    // ----------------------------------------------------------------
    logic in_d_reg;
    logic rise_flag_reg;
    logic fall_flag_reg;
    logic level_hit;
    logic edge_hit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_d_reg <= 1'b0;
        end else begin
            in_d_reg <= irq_bus.input_one;
        end
    end

    // Sticky edges; a new edge wins over the acknowledge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_flag_reg <= 1'b0;
            fall_flag_reg <= 1'b0;
        end else if (soft_clr) begin
            rise_flag_reg <= 1'b0;
            fall_flag_reg <= 1'b0;
        end else begin
            rise_flag_reg <= (irq_bus.input_one & ~in_d_reg)
                           | (rise_flag_reg & ~irq_bus.edge_ack);
            fall_flag_reg <= (~irq_bus.input_one & in_d_reg)
                           | (fall_flag_reg & ~irq_bus.edge_ack);
        end
    end

    // ----------------------------------------------------------------
    // Combine enabled sources
    // ----------------------------------------------------------------
    assign level_hit = (irq_bus.rise_en & irq_bus.input_one)
                     | (irq_bus.fall_en & ~irq_bus.input_one);
    assign edge_hit  = (irq_bus.rise_en & rise_flag_reg)
                     | (irq_bus.fall_en & fall_flag_reg);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_bus.irq_active <= 1'b0;
        end else if (soft_clr) begin
            irq_bus.irq_active <= 1'b0;
        end else begin
            irq_bus.irq_active <= (irq_bus.kind_level ? level_hit : edge_hit)
                                | (irq_bus.wake_en & irq_bus.wake_status)
                                | (irq_bus.disc_en & irq_bus.disc_status);
        end
    end

endmodule : rugi_irq

// *** design/rugi_top.sv ***
`timescale 1ns/1ns
`include "rugi_regs.svh"

// Overview of operation
// - Swap bit crosses plus and minus pairing
// - Qualifier zero forces pin as enable source
// - Direction bit reverses passthrough data flow
// - Source select resets to register control
// - Register enable bit switches passthrough
// - Soft reset returns configuration, port state and interrupt flags to reset values
// - Port disable waits for disconnect if connected
// - Drive type: open drain or push-pull
// - Polarity applies only in push-pull mode
// - Input one rise or high interrupts
// - Input one fall or low interrupts
// - Remote wake interrupt gated by enable
// - Disconnect interrupt gated by enable
// - Interrupt pin shows asserted interrupt

module rugi_top #(
    parameter logic [7:0] REV_CODE = `RUGI_REV_DEFAULT
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Register port from serial target
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Pins
    input  wire logic       uart_enable_pin,
    input  wire logic       general_input_one,
    output logic            interrupt_out_pin_o,
    output logic            interrupt_out_pin_oe,
    // Port status from repeater core
    input  wire logic       port_connected,
    input  wire logic       disconnect_evt,
    input  wire logic       remote_wake_status,
    input  wire logic       disconnect_status,
    input  wire logic       edge_ack,
    // Passthrough and repeater controls
    output logic            uart_passthrough_on,
    output logic            uart_line_swap_out,
    output logic            uart_reverse_out,
    output logic            repeater_disabled,
    output logic            soft_reset_pulse
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic en_pin_meta_reg;
    logic en_pin_reg;
    logic in1_meta_reg;
    logic in1_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_pin_meta_reg <= 1'b0;
            en_pin_reg      <= 1'b0;
            in1_meta_reg    <= 1'b0;
            in1_reg         <= 1'b0;
        end else begin
            en_pin_meta_reg <= uart_enable_pin;
            en_pin_reg      <= en_pin_meta_reg;
            in1_meta_reg    <= general_input_one;
            in1_reg         <= in1_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic wr_uart;
    logic wr_global;
    logic wr_inten;
    logic soft_reset_reg;

    assign wr_uart   = reg_wr && (reg_addr == `RUGI_UART_OFS);
    assign wr_global = reg_wr && (reg_addr == `RUGI_GLOBAL_OFS);
    assign wr_inten  = reg_wr && (reg_addr == `RUGI_INTEN1_OFS);

    // ----------------------------------------------------------------
    // Soft reset
    // ----------------------------------------------------------------
    // One-cycle pulse; the configuration registers, port state and interrupt flags return to reset with it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_reset_reg <= 1'b0;
        end else begin
            soft_reset_reg <= wr_global && reg_wdata[`RUGI_GLB_SOFT_RST];
        end
    end

    assign soft_reset_pulse = soft_reset_reg;

    // ----------------------------------------------------------------
    // Passthrough control register
    // ----------------------------------------------------------------
    rugi_pkg::rugi_uart_cfg_t uart_cfg_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uart_cfg_reg <= rugi_pkg::rugi_uart_cfg_t'(7'h02);
        end else if (soft_reset_reg) begin
            uart_cfg_reg <= rugi_pkg::rugi_uart_cfg_t'(7'h02);
        end else if (wr_uart) begin
            uart_cfg_reg <= rugi_pkg::rugi_uart_cfg_t'({
                reg_wdata[`RUGI_UART_RSV_HI:`RUGI_UART_RSV_LO],
                reg_wdata[`RUGI_UART_SWAP:`RUGI_UART_EN]});
        end
    end

    // ----------------------------------------------------------------
    // Global configuration register
    // ----------------------------------------------------------------
    logic port_disable_reg;
    logic irq_pin_drive_type_reg;
    logic irq_pin_polarity_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_disable_reg       <= 1'b0;
            irq_pin_drive_type_reg <= 1'b0;
            irq_pin_polarity_reg   <= 1'b0;
        end else if (soft_reset_reg) begin
            port_disable_reg       <= 1'b0;
            irq_pin_drive_type_reg <= 1'b0;
            irq_pin_polarity_reg   <= 1'b0;
        end else if (wr_global) begin
            port_disable_reg       <= reg_wdata[`RUGI_GLB_PORT_DIS];
            irq_pin_drive_type_reg <= reg_wdata[`RUGI_GLB_DRIVE];
            irq_pin_polarity_reg   <= reg_wdata[`RUGI_GLB_POL];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt enable register
    // ----------------------------------------------------------------
    logic input_one_rise_irq_en_reg;
    logic input_one_fall_irq_en_reg;
    logic input_one_trigger_kind_reg;
    logic remote_wake_irq_en_reg;
    logic disconnect_irq_en_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_one_rise_irq_en_reg  <= 1'b0;
            input_one_fall_irq_en_reg  <= 1'b0;
            input_one_trigger_kind_reg <= 1'b0;
            remote_wake_irq_en_reg     <= 1'b0;
            disconnect_irq_en_reg      <= 1'b0;
        end else if (soft_reset_reg) begin
            input_one_rise_irq_en_reg  <= 1'b0;
            input_one_fall_irq_en_reg  <= 1'b0;
            input_one_trigger_kind_reg <= 1'b0;
            remote_wake_irq_en_reg     <= 1'b0;
            disconnect_irq_en_reg      <= 1'b0;
        end else if (wr_inten) begin
            input_one_rise_irq_en_reg  <= reg_wdata[`RUGI_IE_RISE];
            input_one_fall_irq_en_reg  <= reg_wdata[`RUGI_IE_FALL];
            input_one_trigger_kind_reg <= reg_wdata[`RUGI_IE_KIND];
            remote_wake_irq_en_reg     <= reg_wdata[`RUGI_IE_WAKE];
            disconnect_irq_en_reg      <= reg_wdata[`RUGI_IE_DISC];
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] rd_next;

    always_comb begin
        rd_next = 8'h00;
        unique case (reg_addr)
            `RUGI_UART_OFS: begin
                rd_next = {uart_cfg_reg.spare, 1'b0, uart_cfg_reg.swap,
                           uart_cfg_reg.qual, uart_cfg_reg.dir,
                           uart_cfg_reg.sel, uart_cfg_reg.en};
            end
            `RUGI_REV_OFS: begin
                rd_next = REV_CODE;
            end
            `RUGI_GLOBAL_OFS: begin
                rd_next = {1'b0, port_disable_reg, 1'b0,
                           irq_pin_drive_type_reg, irq_pin_polarity_reg,
                           3'h0};
            end
            `RUGI_INTEN1_OFS: begin
                rd_next = {input_one_rise_irq_en_reg,
                           input_one_fall_irq_en_reg, 2'h0,
                           remote_wake_irq_en_reg, disconnect_irq_en_reg,
                           1'b0, input_one_trigger_kind_reg};
            end
            // Unmapped addresses read as zero
            default: begin
                rd_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_next;
        end
    end

    // ----------------------------------------------------------------
    // Passthrough steering
    // ----------------------------------------------------------------
    // Pin decides unless qualifier and select both favour the register
    function automatic logic uart_active(
        input rugi_pkg::rugi_uart_cfg_t cfg,
        input logic                     pin
    );
        if (cfg.qual && cfg.sel) begin
            uart_active = cfg.en;
        end else begin
            uart_active = pin;
        end
    endfunction : uart_active

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uart_passthrough_on <= 1'b0;
            uart_line_swap_out  <= 1'b0;
            uart_reverse_out    <= 1'b0;
        end else begin
            uart_passthrough_on <= uart_active(uart_cfg_reg, en_pin_reg);
            uart_line_swap_out  <= uart_cfg_reg.swap;
            uart_reverse_out    <= uart_cfg_reg.dir;
        end
    end

    // ----------------------------------------------------------------
    // Port disable sequencing
    // ----------------------------------------------------------------
    // A live link is never cut mid-session; wait for its disconnect
    rugi_pkg::rugi_port_st_t port_st_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_st_reg <= rugi_pkg::PORT_ON;
        end else if (soft_reset_reg || !port_disable_reg) begin
            port_st_reg <= rugi_pkg::PORT_ON;
        end else begin
            unique case (port_st_reg)
                rugi_pkg::PORT_ON: begin
                    port_st_reg <= port_connected ? rugi_pkg::PORT_WAIT
                                                  : rugi_pkg::PORT_OFF;
                end
                rugi_pkg::PORT_WAIT: begin
                    if (disconnect_evt) begin
                        port_st_reg <= rugi_pkg::PORT_OFF;
                    end
                end
                rugi_pkg::PORT_OFF: begin
                    port_st_reg <= rugi_pkg::PORT_OFF;
                end
                default: begin
                    port_st_reg <= rugi_pkg::PORT_ON;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            repeater_disabled <= 1'b0;
        end else begin
            repeater_disabled <= port_disable_reg && !soft_reset_reg
                && (port_st_reg == rugi_pkg::PORT_OFF);
        end
    end

    // ----------------------------------------------------------------
    // Interrupt sources
    // ----------------------------------------------------------------
    rugi_irq_if irq_bus ();

    assign irq_bus.rise_en     = input_one_rise_irq_en_reg;
    assign irq_bus.fall_en     = input_one_fall_irq_en_reg;
    assign irq_bus.kind_level  = input_one_trigger_kind_reg;
    assign irq_bus.wake_en     = remote_wake_irq_en_reg;
    assign irq_bus.disc_en     = disconnect_irq_en_reg;
    assign irq_bus.input_one   = in1_reg;
    assign irq_bus.wake_status = remote_wake_status;
    assign irq_bus.disc_status = disconnect_status;
    assign irq_bus.edge_ack    = edge_ack;

    rugi_irq u_irq (
        .clk      (clk),
        .rst_n    (rst_n),
        .soft_clr (soft_reset_reg),
        .irq_bus  (irq_bus.irq)
    );

    // ----------------------------------------------------------------
    // Interrupt pin drive
    // ----------------------------------------------------------------
    // Open drain only sinks; push-pull drives both levels always
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_out_pin_o  <= 1'b0;
            interrupt_out_pin_oe <= 1'b0;
        end else if (irq_pin_drive_type_reg) begin
            interrupt_out_pin_oe <= 1'b1;
            interrupt_out_pin_o  <= irq_bus.irq_active ^ irq_pin_polarity_reg;
        end else begin
            interrupt_out_pin_oe <= irq_bus.irq_active;
            interrupt_out_pin_o  <= 1'b0;
        end
    end

endmodule : rugi_top

// *** tb/rugi_top_props.sv ***
`timescale 1ns/1ns

module rugi_top_props #(
    parameter logic [7:0] REV_CODE = 8'h5a
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Pins and status
    input wire logic       general_input_one,
    input wire logic       interrupt_out_pin_o,
    input wire logic       interrupt_out_pin_oe,
    input wire logic       remote_wake_status,
    input wire logic       disconnect_status,
    input wire logic       uart_passthrough_on,
    input wire logic       uart_line_swap_out,
    input wire logic       uart_reverse_out,
    input wire logic       repeater_disabled,
    input wire logic       soft_reset_pulse
);
    // ----------------------------------------------------------------
    // Shadow of configuration writes
    // ----------------------------------------------------------------
    logic [7:0] glb_s;
    logic [7:0] ie_s;
    logic [2:0] age;
    wire        glb_wr = reg_wr && reg_addr == 8'hb2;
    wire        irq_on = glb_s[4] ? (interrupt_out_pin_o ^ glb_s[3]) : interrupt_out_pin_oe;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            glb_s <= 8'h00;
        else if (glb_wr)
            glb_s <= reg_wdata[7] ? 8'h00 : reg_wdata;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            ie_s <= 8'h00;
        else if (glb_wr && reg_wdata[7])
            ie_s <= 8'h00;
        else if (reg_wr && reg_addr == 8'hb3)
            ie_s <= reg_wdata;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            age <= 3'h0;
        else if (reg_wr)
            age <= 3'h0;
        else if (age != 3'h7)
            age <= age + 3'h1;
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_od_low_out: assert property (age >= 3'h4 && !glb_s[4] |-> !interrupt_out_pin_o)
        else $error("open drain pin drives high");
    a_pp_drive_on: assert property (age >= 3'h4 && glb_s[4] |-> interrupt_out_pin_oe)
        else $error("push-pull pin not driven");
    a_wake_gate_on: assert property ((age >= 3'h4 && ie_s[3] && remote_wake_status) [*6] |-> irq_on)
        else $error("wake interrupt not shown");
    a_disc_gate_on: assert property ((age >= 3'h4 && ie_s[2] && disconnect_status) [*6] |-> irq_on)
        else $error("disconnect interrupt not shown");
    a_level_high_irq: assert property ((age >= 3'h4 && ie_s[7] && ie_s[0] && general_input_one) [*7] |-> irq_on)
        else $error("level high irq missing");
    a_level_low_irq: assert property ((age >= 3'h4 && ie_s[6] && ie_s[0] && !general_input_one) [*7] |-> irq_on)
        else $error("level low interrupt missing");
    a_rd_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved");
    a_rev_read: assert property (reg_rd && reg_addr == 8'hb0 |=> reg_rdata == REV_CODE)
        else $error("revision read wrong");
    a_soft_pulse: assert property (glb_wr && reg_wdata[7] |=> soft_reset_pulse ##1 !soft_reset_pulse)
        else $error("soft reset pulse wrong");
    a_uart_follow: assert property (reg_wr && reg_addr == 8'h50 ##1 !reg_wr |=>
        uart_line_swap_out == $past(reg_wdata[4], 2) && uart_reverse_out == $past(reg_wdata[2], 2))
        else $error("swap or dir stale");
    a_reg_pass: assert property (reg_wr && reg_addr == 8'h50 && reg_wdata[3] && reg_wdata[1] ##1 !reg_wr |=>
        uart_passthrough_on == $past(reg_wdata[0], 2))
        else $error("reg enable stale");
    a_dis_clear: assert property (age >= 3'h4 && !glb_s[6] |-> !repeater_disabled)
        else $error("disabled unasked");
endmodule : rugi_top_props

bind rugi_top rugi_top_props #(.REV_CODE(REV_CODE)) props (.*);

// *** tb/rugi_host_model.sv ***
`timescale 1ns/1ns

module rugi_host_model (
    // Clock
    input wire logic       clk,
    // Register port toward the block
    output logic     [7:0] reg_addr,
    output logic           reg_wr,
    output logic           reg_rd,
    output logic     [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #5;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk) #5;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) #5;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk) #5;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask : rd
endmodule : rugi_host_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ns

module tb_top;
    // ----------------------------------------------------------------
    // Clock, reset and wiring
    // ----------------------------------------------------------------
    localparam logic [7:0] REV = 8'h3c;  // Arbitrary value
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic       reg_wr, reg_rd, uart_enable_pin, general_input_one, interrupt_out_pin_o;
    logic       interrupt_out_pin_oe, port_connected, disconnect_evt, remote_wake_status;
    logic       disconnect_status, edge_ack, uart_passthrough_on, uart_line_swap_out;
    logic       uart_reverse_out, repeater_disabled, soft_reset_pulse;
    int         errors = 0;
    int         num_checks = 0;
    int         cycles = 0;
    // Pull-up on the interrupt line
    wire        irq_line = interrupt_out_pin_oe ? interrupt_out_pin_o : 1'b1;
    wire [7:0]  ip = {6'h00, interrupt_out_pin_oe, irq_line};
    wire [7:0]  pt = {5'h00, uart_passthrough_on, uart_line_swap_out, uart_reverse_out};
    wire [7:0]  pd = {6'h00, repeater_disabled, soft_reset_pulse};
    logic [7:0] pt_w [7] = '{8'h1f, 8'h0b, 8'h0a, 8'h03, 8'h03, 8'h09, 8'h09};
    logic       pt_p [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [7:0] pt_e [7] = '{8'h07, 8'h04, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00};
    logic [7:0] gm [4] = '{8'h00, 8'h10, 8'h18, 8'h08};
    logic [7:0] idl [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
    logic [7:0] act [4] = '{8'h02, 8'h03, 8'h02, 8'h02};

    always #25 clk = ~clk;

    rugi_top #(.REV_CODE(REV)) dut (.*);
    rugi_host_model host (.*);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : tick

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rv);
        chk(rv, e);
    endtask : rdc

    task automatic final_report;
        $display("Checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    // Ceiling well above run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {uart_enable_pin, general_input_one, port_connected, disconnect_evt} = 4'h0;
        {remote_wake_status, disconnect_status, edge_ack} = 3'h0;
        tick(16);
        arst_n = 1'b1;
        tick(3);
        rdc(8'h50, 8'h02);
        rdc(8'hb2, 8'h00);
        rdc(8'hb3, 8'h00);
        host.wr(8'hb0, 8'hff);
        rdc(8'hb0, REV);
        rdc(8'h51, 8'h00);
        $display("Test registers done");
        for (int i = 0; i < 7; i++) begin
            uart_enable_pin = pt_p[i];
            host.wr(8'h50, pt_w[i]);
            tick(5);
            chk(pt, pt_e[i]);
        end
        host.wr(8'h50, 8'he9);
        rdc(8'h50, 8'hc9);
        $display("Test passthrough done");
        for (int m = 0; m < 4; m++) begin
            host.wr(8'hb2, gm[m]);
            for (int s = 0; s < 2; s++) begin
                remote_wake_status = (s == 0);
                disconnect_status = (s == 1);
                host.wr(8'hb3, 8'h00);
                tick(6);
                chk(ip, idl[m]);
                host.wr(8'hb3, s ? 8'h04 : 8'h08);
                tick(6);
                chk(ip, act[m]);
            end
        end
        {remote_wake_status, disconnect_status} = 2'h0;
        host.wr(8'hb2, 8'h00);
        host.wr(8'hb3, 8'h81);
        general_input_one = 1'b1;
        tick(8);
        chk(ip, 8'h02);
        general_input_one = 1'b0;
        tick(8);
        chk(ip, 8'h01);
        host.wr(8'hb3, 8'h41);
        tick(8);
        chk(ip, 8'h02);
        for (int e = 0; e < 2; e++) begin
            host.wr(8'hb3, e ? 8'h40 : 8'h80);
            edge_ack = 1'b1;
            tick(1);
            edge_ack = 1'b0;
            tick(6);
            chk(ip, 8'h01);
            general_input_one = ~general_input_one;
            tick(8);
            chk(ip, e ? 8'h01 : 8'h02);
            general_input_one = ~general_input_one;
            tick(8);
            chk(ip, 8'h02);
        end
        $display("Test interrupts done");
        port_connected = 1'b1;
        host.wr(8'hb2, 8'h40);
        tick(6);
        chk(pd, 8'h00);
        disconnect_evt = 1'b1;
        port_connected = 1'b0;
        tick(1);
        disconnect_evt = 1'b0;
        tick(4);
        chk(pd, 8'h02);
        host.wr(8'hb2, 8'h00);
        tick(4);
        chk(pd, 8'h00);
        host.wr(8'hb2, 8'h40);
        tick(4);
        chk(pd, 8'h02);
        $display("Test port disable done");
        host.wr(8'h50, 8'h1f);
        host.wr(8'hb3, 8'h8c);
        host.wr(8'hb2, 8'h98);
        host.wr(8'hb2, 8'h80);
        chk(pd, 8'h01);
        tick(1);
        chk(pd, 8'h00);
        rdc(8'h50, 8'h02);
        rdc(8'hb2, 8'h00);
        rdc(8'hb3, 8'h00);
        $display("Test soft reset done");
        final_report();
    end
endmodule : tb_top
